// [bfs_pkg.sv]
// Package: constants and types of the buck fault supervisor
package bfs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 40;
	localparam int EN_DELAY_NS     = 135000;
	localparam int EN_DELAY_CYC    = (EN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_ON_NS       = 95;
	localparam int MIN_ON_CYC      = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_PULSE_NS   = 35;
	localparam int SYNC_FMIN_KHZ   = 200;
	localparam int SYNC_FMAX_KHZ   = 1600;
	localparam int SYNC_MIN_CYC    = 1000000 / (SYNC_FMAX_KHZ * CLK_PERIOD_NS);
	localparam int SYNC_MAX_CYC    = (1000000 + SYNC_FMIN_KHZ * CLK_PERIOD_NS - 1)
		/ (SYNC_FMIN_KHZ * CLK_PERIOD_NS);
	localparam int PG_GOOD_CYCLES  = 272;
	localparam int PG_FAULT_CYCLES = 16;
	localparam int OC_WAIT_CYCLES  = 512;
	localparam int HICCUP_CYCLES   = 16384;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_PERIOD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_EVENT  = 8'h0c;
	localparam int         CTRL_SYNC_BIT  = 0;
	localparam logic       CTRL_SYNC_RST  = 1'b0;
	localparam logic [7:0] PERIOD_RST     = 8'h32;
	localparam int         EV_HICCUP      = 0;
	localparam int         EV_THERM       = 1;
	localparam int         EV_OVERVOLT    = 2;
	localparam int         EV_PG_FAULT    = 3;
	localparam int         EV_WIDTH       = 4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_OFF, ST_DELAY, ST_RUN, ST_HICCUP, ST_THERM} bfs_state_type;

	typedef struct packed {
		logic feedback_over_108;
		logic feedback_under_89;
		logic feedback_over_106;
		logic feedback_under_91;
		logic soft_start_track_ok;
		logic peak_trip;
		logic overcurrent;
		logic bootstrap_low_lockout;
		logic thermal_trip;
	} bfs_cmp_type;

	typedef struct packed {
		logic [2:0] state;
		logic       sync_locked;
		logic       sync_active;
		logic       ov_block;
		logic       pg_released;
		logic       hs_on;
		logic       ls_on;
	} bfs_status_type;

endpackage

// [bfs_sync_src.sv]
// External synchronisation clock source model
`timescale 1ns/1ps

module bfs_sync_src (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       run,
	input  wire logic [7:0] period,
	output logic            sync_out
);
	logic [7:0] cnt_r;

	// ----------------------------------------------------------------
	// Falling edge opens each period, low for two clocks (80 ns)
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r    <= 8'h00;
			sync_out <= 1'b1;
		end else if (!run) begin
			cnt_r    <= 8'h00;
			sync_out <= 1'b1;
		end else begin
			cnt_r    <= (cnt_r >= period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
			sync_out <= !(cnt_r >= period - 8'h01 || cnt_r == 8'h00);
		end
	end
endmodule

// [bfs_top.sv]
// Module: sequencing, power-good and fault supervision of a buck controller
`timescale 1ns/1ps

module bfs_top #(
	parameter int HICCUP_CYCLES = bfs_pkg::HICCUP_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                nrst,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	input  wire logic                enable_in,
	input  wire logic                undervoltage_lockout,
	input  wire bfs_pkg::bfs_cmp_type cmp,
	input  wire logic                freq_set_sync_in,
	output logic                     hs_gate,
	output logic                     ls_gate,
	output logic                     soft_start_discharge,
	output logic                     power_good_out,
	output logic                     power_good_oe_n
);

	localparam int HW = $clog2(HICCUP_CYCLES + 1);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	bfs_pkg::bfs_state_type           state_r;
	bfs_pkg::bfs_status_type          status;
	logic [31:0]                      hrdata_r;
	logic                             hreadyout_r;
	logic                             hresp_r;
	logic                             wr_pend_r;
	logic [7:0]                       wr_addr_r;
	logic                             ctrl_sync_r;
	logic [7:0]                       period_r;
	logic [bfs_pkg::EV_WIDTH-1:0]     event_r;
	logic [bfs_pkg::EV_WIDTH-1:0]     ev_set;
	logic [bfs_pkg::EV_WIDTH-1:0]     ev_clr;
	logic                             sync_q_r;
	logic                             sync_prev_r;
	logic [7:0]                       per_cnt_r;
	logic                             sync_lock_r;
	logic [7:0]                       osc_cnt_r;
	logic [11:0]                      dly_cnt_r;
	logic [9:0]                       oc_cnt_r;
	logic [HW-1:0]                    hic_cnt_r;
	logic                             hs_r;
	logic                             ls_r;
	logic [1:0]                       on_cnt_r;
	logic                             ov_block_r;
	logic                             pg_ok_r;
	logic [8:0]                       pg_good_cnt_r;
	logic [4:0]                       pg_bad_cnt_r;
	logic                             ss_dis_r;
	logic                             pg_out_r;
	logic                             acc;
	logic                             sync_fall;
	logic                             sync_active;
	logic                             osc_tick;
	logic                             cycle_tick;
	logic                             run;
	logic                             go_hiccup;
	logic                             imm_low;
	logic                             in_reg;
	logic                             out_fault;
	logic                             pg_fault_drop;
	logic                             min_on_done;
	logic                             hs_block;

	function automatic logic in_range(input logic [7:0] cnt);
		in_range = (cnt >= 8'(bfs_pkg::SYNC_MIN_CYC - 1)) && (cnt <= 8'(bfs_pkg::SYNC_MAX_CYC - 1));
	endfunction

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	assign acc    = hsel && hready && htrans[1];
	assign ev_clr = (wr_pend_r && wr_addr_r == bfs_pkg::REG_EVENT) ?
		hwdata[bfs_pkg::EV_WIDTH-1:0] : '0;
	assign status = '{state: state_r, sync_locked: sync_lock_r, sync_active: sync_active,
		ov_block: ov_block_r, pg_released: pg_ok_r, hs_on: hs_r, ls_on: ls_r};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= 8'h00;
			hrdata_r    <= 32'h0000_0000;
			hreadyout_r <= 1'b0;
			hresp_r     <= 1'b0;
		end else begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
			wr_pend_r   <= acc && hwrite;
			wr_addr_r   <= haddr[7:0];
			if (acc && !hwrite) begin
				if (haddr[7:0] == bfs_pkg::REG_CTRL) begin
					hrdata_r <= {31'h0000_0000, ctrl_sync_r};
				end else if (haddr[7:0] == bfs_pkg::REG_PERIOD) begin
					hrdata_r <= {24'h00_0000, period_r};
				end else if (haddr[7:0] == bfs_pkg::REG_STATUS) begin
					hrdata_r <= {23'h00_0000, status};
				end else if (haddr[7:0] == bfs_pkg::REG_EVENT) begin
					hrdata_r <= {28'h000_0000, event_r};
				end else begin
					hrdata_r <= 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_sync_r <= bfs_pkg::CTRL_SYNC_RST;
			period_r    <= bfs_pkg::PERIOD_RST;
		end else if (wr_pend_r) begin
			if (wr_addr_r == bfs_pkg::REG_CTRL) begin
				ctrl_sync_r <= hwdata[bfs_pkg::CTRL_SYNC_BIT];
			end else if (wr_addr_r == bfs_pkg::REG_PERIOD) begin
				period_r <= hwdata[7:0];
			end
		end
	end

	// Sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			event_r <= '0;
		end else begin
			event_r <= (event_r & ~ev_clr) | ev_set;
		end
	end

	// ----------------------------------------------------------------
	// Switching clock: internal oscillator or external sync
	// ----------------------------------------------------------------
	assign sync_fall   = sync_prev_r && !sync_q_r;
	assign sync_active = ctrl_sync_r && sync_lock_r;
	assign osc_tick    = (osc_cnt_r >= period_r - 8'h01);
	assign cycle_tick  = sync_active ? sync_fall : osc_tick;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_q_r    <= 1'b0;
			sync_prev_r <= 1'b0;
			per_cnt_r   <= 8'h00;
			sync_lock_r <= 1'b0;
		end else begin
			sync_q_r    <= freq_set_sync_in;
			sync_prev_r <= sync_q_r;
			if (sync_fall) begin
				per_cnt_r   <= 8'h00;
				sync_lock_r <= in_range(per_cnt_r);
			end else if (per_cnt_r != 8'(bfs_pkg::SYNC_MAX_CYC)) begin
				per_cnt_r <= per_cnt_r + 8'h01;
			end else begin
				sync_lock_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			osc_cnt_r <= 8'h00;
		end else if (osc_tick) begin
			osc_cnt_r <= 8'h00;
		end else begin
			osc_cnt_r <= osc_cnt_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Sequencing: enable delay, hiccup, thermal restart
	// ----------------------------------------------------------------
	assign run       = (state_r == bfs_pkg::ST_RUN);
	assign go_hiccup = run && cycle_tick && cmp.overcurrent &&
		oc_cnt_r == 10'(bfs_pkg::OC_WAIT_CYCLES - 1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= bfs_pkg::ST_OFF;
		end else if (!enable_in || undervoltage_lockout) begin
			state_r <= bfs_pkg::ST_OFF;
		end else if (cmp.thermal_trip && state_r != bfs_pkg::ST_OFF) begin
			state_r <= bfs_pkg::ST_THERM;
		end else begin
			case (state_r)
				bfs_pkg::ST_OFF: state_r <= bfs_pkg::ST_DELAY;
				bfs_pkg::ST_DELAY: begin
					if (dly_cnt_r == 12'(bfs_pkg::EN_DELAY_CYC - 1)) begin
						state_r <= bfs_pkg::ST_RUN;
					end
				end
				bfs_pkg::ST_RUN: begin
					if (go_hiccup) begin
						state_r <= bfs_pkg::ST_HICCUP;
					end
				end
				bfs_pkg::ST_HICCUP: begin
					if (cycle_tick && hic_cnt_r == HW'(HICCUP_CYCLES - 1)) begin
						state_r <= bfs_pkg::ST_RUN;
					end
				end
				default: state_r <= bfs_pkg::ST_RUN;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dly_cnt_r <= 12'h000;
		end else if (state_r == bfs_pkg::ST_DELAY) begin
			dly_cnt_r <= dly_cnt_r + 12'h001;
		end else begin
			dly_cnt_r <= 12'h000;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			oc_cnt_r  <= 10'h000;
			hic_cnt_r <= '0;
		end else begin
			if (!run || !cmp.overcurrent || go_hiccup) begin
				oc_cnt_r <= 10'h000;
			end else if (cycle_tick) begin
				oc_cnt_r <= oc_cnt_r + 10'h001;
			end
			if (state_r != bfs_pkg::ST_HICCUP) begin
				hic_cnt_r <= '0;
			end else if (cycle_tick) begin
				hic_cnt_r <= hic_cnt_r + HW'(1);
			end
		end
	end

	// Soft-start held discharged whenever not regulating, so each start is fresh
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ss_dis_r <= 1'b1;
		end else begin
			ss_dis_r <= !run;
		end
	end

	// ----------------------------------------------------------------
	// Power stage gate control
	// ----------------------------------------------------------------
	assign min_on_done = on_cnt_r >= 2'(bfs_pkg::MIN_ON_CYC - 1);
	assign hs_block    = ov_block_r || cmp.feedback_over_108 || cmp.bootstrap_low_lockout;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ov_block_r <= 1'b0;
		end else if (cmp.feedback_over_108) begin
			ov_block_r <= 1'b1;
		end else if (!cmp.feedback_over_106) begin
			ov_block_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hs_r     <= 1'b0;
			ls_r     <= 1'b0;
			on_cnt_r <= 2'h0;
		end else if (!run) begin
			hs_r <= 1'b0;
			ls_r <= 1'b0;
		end else if (hs_r) begin
			if (!min_on_done) begin
				on_cnt_r <= on_cnt_r + 2'h1;
			end else if (cmp.peak_trip || hs_block) begin
				hs_r <= 1'b0;
				ls_r <= 1'b1;
			end
		end else if (cycle_tick && !hs_block) begin
			hs_r     <= 1'b1;
			ls_r     <= 1'b0;
			on_cnt_r <= 2'h0;
		end else if (cmp.bootstrap_low_lockout) begin
			ls_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Power-good supervisor
	// ----------------------------------------------------------------
	assign imm_low   = !enable_in || undervoltage_lockout || cmp.thermal_trip;
	assign in_reg    = !cmp.feedback_under_91 && !cmp.feedback_over_106 &&
		cmp.soft_start_track_ok;
	assign out_fault = cmp.feedback_under_89 || cmp.feedback_over_108;
	assign pg_fault_drop = pg_ok_r && !imm_low && out_fault && cycle_tick &&
		pg_bad_cnt_r == 5'(bfs_pkg::PG_FAULT_CYCLES - 1);
	assign ev_set = {pg_fault_drop, cmp.feedback_over_108 && !ov_block_r,
		cmp.thermal_trip && state_r != bfs_pkg::ST_THERM && state_r != bfs_pkg::ST_OFF,
		go_hiccup};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pg_ok_r       <= 1'b0;
			pg_good_cnt_r <= 9'h000;
			pg_bad_cnt_r  <= 5'h00;
		end else if (imm_low) begin
			pg_ok_r       <= 1'b0;
			pg_good_cnt_r <= 9'h000;
			pg_bad_cnt_r  <= 5'h00;
		end else if (pg_ok_r) begin
			pg_good_cnt_r <= 9'h000;
			if (!out_fault) begin
				pg_bad_cnt_r <= 5'h00;
			end else if (pg_fault_drop) begin
				pg_ok_r      <= 1'b0;
				pg_bad_cnt_r <= 5'h00;
			end else if (cycle_tick) begin
				pg_bad_cnt_r <= pg_bad_cnt_r + 5'h01;
			end
		end else begin
			pg_bad_cnt_r <= 5'h00;
			if (!in_reg) begin
				pg_good_cnt_r <= 9'h000;
			end else if (cycle_tick &&
				pg_good_cnt_r == 9'(bfs_pkg::PG_GOOD_CYCLES - 1)) begin
				pg_ok_r       <= 1'b1;
				pg_good_cnt_r <= 9'h000;
			end else if (cycle_tick) begin
				pg_good_cnt_r <= pg_good_cnt_r + 9'h001;
			end
		end
	end

	// Open drain: the pin level is always low, the enable releases it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pg_out_r <= 1'b0;
		end else begin
			pg_out_r <= 1'b0;
		end
	end

	assign hrdata               = hrdata_r;
	assign hreadyout            = hreadyout_r;
	assign hresp                = hresp_r;
	assign hs_gate              = hs_r;
	assign ls_gate              = ls_r;
	assign soft_start_discharge = ss_dis_r;
	assign power_good_out       = pg_out_r;
	assign power_good_oe_n      = pg_ok_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_EN_DELAY: assert property (
		$past(state_r) == bfs_pkg::ST_DELAY && run |->
			$past(dly_cnt_r) == 12'(bfs_pkg::EN_DELAY_CYC - 1))
		else $error("switching started before enable delay");
	AST_PG_RELEASE: assert property (
		$rose(pg_ok_r) |-> $past(pg_good_cnt_r) == 9'(bfs_pkg::PG_GOOD_CYCLES - 1)
			&& $past(in_reg))
		else $error("power-good released without full deglitch");
	AST_PG_FAULT: assert property (
		$fell(pg_ok_r) && !$past(imm_low) |->
			$past(pg_bad_cnt_r) == 5'(bfs_pkg::PG_FAULT_CYCLES - 1))
		else $error("power-good dropped without fault deglitch");
	AST_HICCUP_IN: assert property (
		$past(run) && state_r == bfs_pkg::ST_HICCUP |->
			$past(oc_cnt_r) == 10'(bfs_pkg::OC_WAIT_CYCLES - 1))
		else $error("hiccup entered early");
	AST_HICCUP_OUT: assert property (
		$past(state_r) == bfs_pkg::ST_HICCUP && run |->
			$past(hic_cnt_r) == HW'(HICCUP_CYCLES - 1) && ss_dis_r)
		else $error("hiccup left early or without soft-start");
	AST_SYNC_EDGE: assert property (
		sync_active && run && !hs_r && enable_in && !undervoltage_lockout && !cmp.thermal_trip
			|=> hs_r == $past(sync_fall && !hs_block))
		else $error("cycle not aligned to external falling edge");
	AST_MIN_ON: assert property (
		$rose(hs_r) |-> (hs_r || !run)[*3])
		else $error("high-side on time too short");
	AST_OV_BLOCK: assert property (
		ov_block_r && !hs_r |=> !hs_r)
		else $error("high-side turned on under overvoltage");
	AST_THERMAL: assert property (
		cmp.thermal_trip && enable_in && !undervoltage_lockout && run |=> !run ##1 !hs_r)
		else $error("switching continued during thermal trip");
	AST_BOOT: assert property (
		run && !hs_r && cmp.bootstrap_low_lockout && enable_in && !undervoltage_lockout
			&& !cmp.thermal_trip |=> ls_r && !hs_r)
		else $error("bootstrap recharge not forced");
	AST_TICK_ON: assert property (
		run && !hs_r && cycle_tick && !hs_block && enable_in && !undervoltage_lockout
			&& !cmp.thermal_trip |=> hs_r && !ls_r)
		else $error("tick did not start high-side");
	AST_PEAK: assert property (
		run && hs_r && min_on_done && cmp.peak_trip && enable_in && !undervoltage_lockout
			&& !cmp.thermal_trip |=> !hs_r && ls_r)
		else $error("peak trip did not commutate");
	AST_PG_IMM: assert property (
		imm_low |=> !power_good_oe_n)
		else $error("power-good not pulled low at once");

	COV_PG_UP: cover property ($rose(pg_ok_r));
	COV_HICCUP: cover property (state_r == bfs_pkg::ST_HICCUP ##1 run);
	COV_SYNC: cover property (sync_active && cycle_tick);
	COV_THERM: cover property (state_r == bfs_pkg::ST_THERM ##1 run);

endmodule

// [tb.sv]
// Testbench of the buck fault supervisor
`timescale 1ns/1ps

module tb;
	logic                 clk = 1'b0;
	logic                 nrst = 1'b0;
	logic                 hsel = 1'b0;
	logic [31:0]          haddr = 32'h0;
	logic [1:0]           htrans = 2'h0;
	logic                 hwrite = 1'b0;
	logic [31:0]          hwdata = 32'h0;
	logic [31:0]          hrdata;
	logic                 hready;
	logic                 en = 1'b0;
	logic                 uv_lock = 1'b0;
	logic                 resp;
	logic                 pg_lvl;
	bfs_pkg::bfs_cmp_type cmp = 9'h0a0;
	logic                 sync_run = 1'b0;
	logic [7:0]           sync_per = 8'h10;
	logic [7:0]           pers [2] = '{8'h10, 8'h7c};
	logic                 sync;
	logic                 hs;
	logic                 ls;
	logic                 ssd;
	logic                 pg_n;
	int                   error_cnt = 0;
	int                   compares = 0;
	int                   c;
	int                   c1;
	logic [31:0]          q;

	always #20 clk = ~clk;

	bfs_sync_src src (.clk(clk), .nrst(nrst), .run(sync_run), .period(sync_per), .sync_out(sync));

	bfs_top #(.HICCUP_CYCLES(64)) uut (
		.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(resp), .enable_in(en), .undervoltage_lockout(uv_lock),
		.cmp(cmp), .freq_set_sync_in(sync), .hs_gate(hs), .ls_gate(ls),
		.soft_start_discharge(ssd), .power_good_out(pg_lvl), .power_good_oe_n(pg_n)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rng(input string nm, input int lo, input int hi, input int g);
		compares++;
		if (g < lo || g > hi) begin
			error_cnt++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask

	task automatic stc(input bfs_pkg::bfs_state_type e);
		bus(1'b0, bfs_pkg::REG_STATUS, 32'h0);
		chk("state", {29'h0, e}, {29'h0, q[8:6]});
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return pg_n;
			1: return hs;
			2: return ls;
			3: return ssd;
			default: return sync;
		endcase
	endfunction

	// Counts falling clock edges until the level shows; n+1 means never
	task automatic ws(input int s, input logic v, input int n);
		for (c = 1; c <= n; c++) begin
			@(negedge clk);
			if (pick(s) === v) break;
		end
		@(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("pg_oe_n", 32'h0, {31'h0, pg_n});
		rdc("ctrl", bfs_pkg::REG_CTRL, 32'h0);
		chk("hresp", 32'h0, {31'h0, resp});
		rdc("period", bfs_pkg::REG_PERIOD, {24'h0, bfs_pkg::PERIOD_RST});
		rdc("event", bfs_pkg::REG_EVENT, 32'h0);
		rdc("unmapped", 8'h10, 32'h0);
		stc(bfs_pkg::ST_OFF);
		bus(1'b1, bfs_pkg::REG_PERIOD, 32'h0a);
		rdc("period", bfs_pkg::REG_PERIOD, 32'h0a);
		en <= 1'b1;
		ws(1, 1'b1, 3500);
		rng("start_delay", 3376, 3392, c);
		cmp <= 9'h010;
		repeat (1500) @(posedge clk);
		chk("pg_early", 32'h0, {31'h0, pg_n});
		cmp.soft_start_track_ok <= 1'b0;
		@(posedge clk);
		cmp.soft_start_track_ok <= 1'b1;
		ws(0, 1'b1, 2800);
		rng("pg_release", 2700, 2740, c);
		chk("pg_level", 32'h0, {31'h0, pg_lvl});
		cmp.feedback_under_89 <= 1'b1;
		cmp.feedback_under_91 <= 1'b1;
		ws(0, 1'b0, 200);
		rng("pg_fault", 145, 180, c);
		rdc("event_pg", bfs_pkg::REG_EVENT, 32'h8);
		bus(1'b1, bfs_pkg::REG_EVENT, 32'h8);
		rdc("event_clr", bfs_pkg::REG_EVENT, 32'h0);
		cmp <= 9'h010;
		ws(0, 1'b1, 2800);
		rng("pg_again", 2700, 2740, c);
		cmp.thermal_trip <= 1'b1;
		ws(0, 1'b0, 4);
		rng("pg_therm", 1, 2, c);
		stc(bfs_pkg::ST_THERM);
		chk("gates_off", 32'h0, {30'h0, hs, ls});
		cmp.thermal_trip <= 1'b0;
		ws(3, 1'b0, 20);
		rng("therm_restart", 1, 3, c);
		ws(1, 1'b1, 20);
		rng("tick_on", 1, 20, c);
		cmp.peak_trip <= 1'b1;
		ws(2, 1'b1, 8);
		rng("peak_off", 2, 4, c);
		chk("hs_peak", 32'h0, {31'h0, hs});
		cmp.peak_trip <= 1'b0;
		ws(1, 1'b1, 14);
		rng("next_tick", 1, 13, c);
		ws(1, 1'b0, 40);
		rng("full_duty", 41, 41, c);
		cmp.bootstrap_low_lockout <= 1'b1;
		ws(2, 1'b1, 6);
		rng("boot_recharge", 1, 3, c);
		cmp.bootstrap_low_lockout <= 1'b0;
		cmp.feedback_over_106 <= 1'b1;
		cmp.feedback_over_108 <= 1'b1;
		repeat (30) @(posedge clk);
		chk("ov_hs", 32'h0, {31'h0, hs});
		cmp.feedback_over_108 <= 1'b0;
		ws(1, 1'b1, 30);
		rng("ov_hold", 31, 31, c);
		cmp.feedback_over_106 <= 1'b0;
		ws(1, 1'b1, 20);
		rng("ov_release", 1, 13, c);
		bus(1'b0, bfs_pkg::REG_EVENT, 32'h0);
		chk("event_ov", 32'h4, q & 32'h4);
		chk("event_all", 32'h6, q);
		bus(1'b1, bfs_pkg::REG_EVENT, 32'hf);
		cmp.overcurrent <= 1'b1;
		ws(3, 1'b1, 5200);
		rng("hiccup_wait", 5100, 5140, c);
		stc(bfs_pkg::ST_HICCUP);
		cmp.overcurrent <= 1'b0;
		ws(3, 1'b0, 700);
		rng("hiccup_time", 610, 660, c);
		bus(1'b0, bfs_pkg::REG_EVENT, 32'h0);
		chk("event_hic", 32'h1, q & 32'h1);
		bus(1'b1, bfs_pkg::REG_CTRL, 32'h1);
		sync_run <= 1'b1;
		cmp.peak_trip <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			sync_per <= pers[i];
			repeat (400) @(posedge clk);
			bus(1'b0, bfs_pkg::REG_STATUS, 32'h0);
			chk("locked", 32'h1, {31'h0, q[5]});
			ws(4, 1'b1, 200);
			ws(4, 1'b0, 200);
			ws(1, 1'b1, 8);
			rng("sync_align", 2, 2, c);
			ws(1, 1'b0, 200);
			c1 = c;
			ws(1, 1'b1, 200);
			rng("sync_period", pers[i], pers[i], c1 + c);
		end
		uv_lock <= 1'b1;
		ws(3, 1'b1, 4);
		rng("lockout", 1, 3, c);
		chk("pg_low_lock", 32'h0, {31'h0, pg_n});
		chk("pg_level_end", 32'h0, {31'h0, pg_lvl});
		stc(bfs_pkg::ST_OFF);
		end_sim();
	end
endmodule
